// ### verilog/ssa_cfg.svh
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH

// register byte offsets
`define SSA_OFS_CTRL 8'h00
`define SSA_OFS_ACC 8'h04
`define SSA_OFS_FLAGS 8'h08
`define SSA_OFS_MEM 8'h40

// command word field positions
`define SSA_CTRL_OP_LSB 0
`define SSA_CTRL_ADDR_LSB 8
`define SSA_CTRL_IMM_LSB 16

// flag register bit positions
`define SSA_FLAG_C_BIT 0
`define SSA_FLAG_AC_BIT 1
`define SSA_FLAG_Z_BIT 2
`define SSA_FLAG_OV_BIT 3

// reset values
`define SSA_RST_ACC 8'h00
`define SSA_RST_FLAGS 4'h0
`define SSA_RST_MEM 8'h00

// axi responses
`define SSA_RESP_OKAY 2'h0
`define SSA_RESP_SLVERR 2'h2

`endif

// ### verilog/ssa_pkg.sv
package ssa_pkg;

    // instruction selected by the command word
    typedef enum logic [1:0] {
        SSA_OP_SUB_ACC,
        SSA_OP_DIFFERENCE_TO_MEMORY,
        SSA_OP_SUB_IMM,
        SSA_OP_SWAP
    } ssa_op_e;

    // status flags, carry in bit 0
    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } ssa_flags_s;

    // command word low 24 bits
    typedef struct packed {
        logic [7:0] imm;
        logic [7:0] addr;
        logic [5:0] pad;
        ssa_op_e op;
    } ssa_cmd_s;

    // difference with its flags
    typedef struct packed {
        logic [7:0] diff;
        ssa_flags_s flags;
    } ssa_res_s;

    // region hit by a register address
    typedef enum logic [1:0] {
        SSA_REG_CTRL,
        SSA_REG_ACC,
        SSA_REG_FLAGS,
        SSA_REG_MEM
    } ssa_reg_e;

endpackage

// ### verilog/ssa_alu.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "ssa_cfg.svh"
// Operation
// - subtract-to-accumulator puts accumulator minus the memory byte in the accumulator and updates all four flags.
// - every subtract clears carry on a borrow and sets it when the difference is zero or positive.
// - subtract-to-memory writes accumulator minus the byte back to that byte, keeps the accumulator, updates flags.
// - immediate subtract puts accumulator minus the command constant in the accumulator and updates the flags.
// - memory subtracts are always accumulator minus memory, never the other way round.
// - the swap exchanges the two nibbles of the memory byte in place and leaves every flag alone.
module ssa_alu #(
    parameter int MEM_DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int AW = $clog2(MEM_DEPTH);

    logic [7:0] aw_addr_ff;
    logic aw_held_ff;
    logic [31:0] w_data_ff;
    logic w_strb0_ff;
    logic w_held_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] acc_ff;
    ssa_pkg::ssa_flags_s flags_ff;
    ssa_pkg::ssa_cmd_s cmd_ff;
    logic [7:0] mem_ff [MEM_DEPTH];

    // map a byte address to a register; top bit says whether it exists
    function automatic logic [2:0] ssa_decode(input logic [7:0] a);
        logic [7:0] top;
        top = 8'(`SSA_OFS_MEM + MEM_DEPTH * 4);
        if (a[1:0] != 2'h0) begin
            return {1'b0, ssa_pkg::SSA_REG_CTRL};
        end
        if (a >= `SSA_OFS_MEM && a < top) begin
            return {1'b1, ssa_pkg::SSA_REG_MEM};
        end
        unique case (a)
            `SSA_OFS_CTRL: return {1'b1, ssa_pkg::SSA_REG_CTRL};
            `SSA_OFS_ACC: return {1'b1, ssa_pkg::SSA_REG_ACC};
            `SSA_OFS_FLAGS: return {1'b1, ssa_pkg::SSA_REG_FLAGS};
            default: return {1'b0, ssa_pkg::SSA_REG_CTRL};
        endcase
    endfunction

    // subtract a - b with the four status flags
    function automatic ssa_pkg::ssa_res_s ssa_sub(input logic [7:0] a, input logic [7:0] b);
        ssa_pkg::ssa_res_s r;
        logic [8:0] d9;
        d9 = {1'b0, a} - {1'b0, b};
        r.diff = d9[7:0];
        r.flags.carry_flag = ~d9[8];
        r.flags.zero_flag = (d9[7:0] == 8'h00);
        r.flags.half_carry_flag = (a[3:0] >= b[3:0]);
        r.flags.signed_wrap_flag = (a[7] ^ b[7]) & (a[7] ^ d9[7]);
        return r;
    endfunction

    // write channel decode: a write is done once address and data are both held and no write response is still pending
    wire wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire [2:0] wr_dec = ssa_decode(aw_addr_ff);
    wire wr_ok = wr_dec[2];
    wire ssa_pkg::ssa_reg_e wr_reg = ssa_pkg::ssa_reg_e'(wr_dec[1:0]);
    wire wr_en = wr_go & wr_ok & w_strb0_ff; // lane 0 gates every register
    wire wr_ctrl = wr_en & (wr_reg == ssa_pkg::SSA_REG_CTRL);
    wire wr_acc = wr_en & (wr_reg == ssa_pkg::SSA_REG_ACC);
    wire wr_flags = wr_en & (wr_reg == ssa_pkg::SSA_REG_FLAGS);
    wire wr_mem = wr_en & (wr_reg == ssa_pkg::SSA_REG_MEM);
    wire [AW-1:0] wr_idx = aw_addr_ff[AW+1:2];

    // instruction datapath, executed in the cycle the command word is written
    wire ssa_pkg::ssa_cmd_s cmd_w = ssa_pkg::ssa_cmd_s'(w_data_ff[23:0]);
    wire ssa_pkg::ssa_op_e op_w = cmd_w.op;
    wire [AW-1:0] op_idx = cmd_w.addr[AW-1:0]; // upper address bits wrap
    wire [7:0] opnd = mem_ff[op_idx];
    // immediate form takes the constant from the command
    wire [7:0] sub_b = (op_w == ssa_pkg::SSA_OP_SUB_IMM) ? cmd_w.imm : opnd;
    wire ssa_pkg::ssa_res_s res = ssa_sub(acc_ff, sub_b);
    wire [7:0] swapped = {opnd[3:0], opnd[7:4]};
    wire is_swap = (op_w == ssa_pkg::SSA_OP_SWAP);
    wire is_dtm = (op_w == ssa_pkg::SSA_OP_DIFFERENCE_TO_MEMORY);

    // destination steering
    // memory form and swap write the byte, only subtracts reach flags
    wire mem_we = wr_mem | (wr_ctrl & (is_dtm | is_swap));
    wire [AW-1:0] mem_wa = wr_mem ? wr_idx : op_idx;
    wire [7:0] mem_wd = wr_mem ? w_data_ff[7:0] : (is_swap ? swapped : res.diff);
    wire acc_we = wr_acc | (wr_ctrl & ~is_dtm & ~is_swap);
    wire [7:0] nxt_acc = wr_acc ? w_data_ff[7:0] : res.diff;
    wire flags_we = wr_flags | (wr_ctrl & ~is_swap);
    wire ssa_pkg::ssa_flags_s nxt_flags = wr_flags ? ssa_pkg::ssa_flags_s'(w_data_ff[3:0]) : res.flags;

    // read decode
    wire [2:0] rd_dec = ssa_decode(araddr);
    wire ssa_pkg::ssa_reg_e rd_reg = ssa_pkg::ssa_reg_e'(rd_dec[1:0]);
    wire rd_go = arvalid & ~rvalid_ff;
    wire [31:0] rd_word = ~rd_dec[2] ? 32'h0000_0000 :
        (rd_reg == ssa_pkg::SSA_REG_CTRL) ? {8'h00, cmd_ff} :
        (rd_reg == ssa_pkg::SSA_REG_ACC) ? {24'h00_0000, acc_ff} :
        (rd_reg == ssa_pkg::SSA_REG_FLAGS) ? {28'h000_0000, flags_ff} :
        {24'h00_0000, mem_ff[araddr[AW+1:2]]};

    // handshake outputs
    assign awready = ~aw_held_ff;
    assign wready = ~w_held_ff;
    assign arready = ~rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    // write address and data are held independently so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb0_ff <= 1'b0;
        end else begin
            aw_held_ff <= (aw_held_ff & ~wr_go) | (awvalid & ~aw_held_ff);
            w_held_ff <= (w_held_ff & ~wr_go) | (wvalid & ~w_held_ff);
            if (awvalid && !aw_held_ff) begin
                aw_addr_ff <= awaddr;
            end
            if (wvalid && !w_held_ff) begin
                w_data_ff <= wdata;
                w_strb0_ff <= wstrb[0];
            end
        end
    end

    // write response, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `SSA_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `SSA_RESP_OKAY : `SSA_RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read answer, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `SSA_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_dec[2] ? `SSA_RESP_OKAY : `SSA_RESP_SLVERR;
            rdata_ff <= rd_word;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // accumulator, flags and last command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= `SSA_RST_ACC;
            flags_ff <= `SSA_RST_FLAGS;
            cmd_ff <= '0;
        end else begin
            if (acc_we) begin
                acc_ff <= nxt_acc;
            end
            if (flags_we) begin
                flags_ff <= nxt_flags;
            end
            if (wr_ctrl) begin
                cmd_ff <= cmd_w;
            end
        end
    end

    // data memory; one writer per cycle since commands arrive over the same write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_ff[i] <= `SSA_RST_MEM;
            end
        end else if (mem_we) begin
            mem_ff[mem_wa] <= mem_wd;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // per-operation execute strobes for the checks below
    wire ex_acc = wr_ctrl & (op_w == ssa_pkg::SSA_OP_SUB_ACC);
    wire ex_imm = wr_ctrl & (op_w == ssa_pkg::SSA_OP_SUB_IMM);
    wire ex_dtm = wr_ctrl & is_dtm;
    wire ex_swap = wr_ctrl & is_swap;

    sub_acc_result_a: assert property (
        ex_acc |=> acc_ff == 8'($past(acc_ff) - $past(opnd)))
        else $error("accumulator subtract result wrong");
    carry_borrow_a: assert property (
        (ex_acc | ex_imm | ex_dtm) |=> flags_ff.carry_flag == ($past(acc_ff) >= $past(sub_b)))
        else $error("carry does not reflect borrow");
    mem_dest_a: assert property (
        ex_dtm |=> acc_ff == $past(acc_ff) && mem_ff[$past(op_idx)] == 8'($past(acc_ff) - $past(opnd)))
        else $error("memory destination subtract wrong");
    imm_result_a: assert property (
        ex_imm |=> acc_ff == 8'($past(acc_ff) - $past(cmd_w.imm)))
        else $error("immediate subtract result wrong");
    operand_order_a: assert property (
        (ex_acc && acc_ff > opnd) |=> !flags_ff.zero_flag && flags_ff.carry_flag)
        else $error("operands taken in wrong order");
    swap_inplace_a: assert property (
        ex_swap |=> $stable(flags_ff) && $stable(acc_ff)
            && mem_ff[$past(op_idx)] == {$past(opnd[3:0]), $past(opnd[7:4])})
        else $error("swap wrong or flags disturbed");
    flag_math_a: assert property (
        ex_acc |=> flags_ff.zero_flag == (acc_ff == 8'h00)
            && flags_ff.signed_wrap_flag == (($past(acc_ff[7]) ^ $past(opnd[7])) & ($past(acc_ff[7]) ^ acc_ff[7]))
            && flags_ff.half_carry_flag == ($past(acc_ff[3:0]) >= $past(opnd[3:0])))
        else $error("zero, wrap or half carry wrong");
    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    cov_borrow_c: cover property (ex_acc && acc_ff < opnd);
    cov_dtm_c: cover property (ex_dtm ##[1:400] ex_swap);
    cov_wrap_c: cover property (ex_imm ##1 flags_ff.signed_wrap_flag);

endmodule // ssa_alu

// ### verification/test_subtract_swap_alu_ops.sv
`timescale 1ns/1ps
`include "ssa_cfg.svh"
// compares one value, counts it, reports a mismatch at once
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_subtract_swap_alu_ops;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int num_errors = 0;
    int check_count = 0;
    int cycle_count = 0;
    // op, accumulator, memory byte, immediate
    localparam logic [31:0] CASES [0:7] = '{32'h00_50_30_00, 32'h00_30_50_00, 32'h00_80_01_00,
        32'h01_44_44_00, 32'h01_10_20_00, 32'h02_7F_00_FF, 32'h02_05_00_06, 32'h03_12_A5_00};

    ssa_alu ssa_alu_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // 50 MHz clock
    always #10 aclk = ~aclk;

    // hang guard: far above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycle_count++;
        if (cycle_count >= 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // handshakes are judged at the falling edge, when both sides have settled for the next rise
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        bit aw_hs, w_hs, done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            aw_hs = awvalid && (awready === 1'b1);
            w_hs = wvalid && (wready === 1'b1);
            done = (bvalid === 1'b1);
            resp = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit ar_hs, done;
        done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar_hs = arvalid && (arready === 1'b1);
            done = (rvalid === 1'b1);
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
    endtask

    function automatic logic [3:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction

    initial begin
        logic [31:0] rd, cmd;
        logic [1:0] rsp;
        logic [7:0] op, acc_v, mem_v, imm_v, sub_v, exp_acc, exp_mem, mem_ofs;
        logic [3:0] exp_flg;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // reset contents all zero
        axi_read(`SSA_OFS_ACC, rd, rsp);
        `CHECK(rd, 32'h0)
        axi_read(`SSA_OFS_FLAGS, rd, rsp);
        `CHECK(rd, 32'h0)
        axi_read(`SSA_OFS_MEM + 8'h0C, rd, rsp);
        `CHECK(rd, 32'h0)
        for (int i = 0; i < 8; i++) begin
            {op, acc_v, mem_v, imm_v} = CASES[i];
            mem_ofs = `SSA_OFS_MEM + 8'(4 * (i + 3));
            axi_write(`SSA_OFS_ACC, {24'h0, acc_v}, 4'hF, rsp);
            axi_write(mem_ofs, {24'h0, mem_v}, 4'hF, rsp);
            axi_write(`SSA_OFS_FLAGS, 32'h5, 4'hF, rsp);
            cmd = {8'h00, imm_v, 8'(i + 3), 6'h00, op[1:0]};
            axi_write(`SSA_OFS_CTRL, cmd, 4'hF, rsp);
            `CHECK(rsp, `SSA_RESP_OKAY)
            sub_v = (op == 8'h02) ? imm_v : mem_v;
            exp_flg = (op == 8'h03) ? 4'h5 : sub_flags(acc_v, sub_v);
            exp_acc = (op == 8'h00 || op == 8'h02) ? acc_v - sub_v : acc_v;
            exp_mem = (op == 8'h01) ? acc_v - mem_v : (op == 8'h03) ? {mem_v[3:0], mem_v[7:4]} : mem_v;
            axi_read(`SSA_OFS_ACC, rd, rsp);
            `CHECK(rd, {24'h0, exp_acc})
            axi_read(mem_ofs, rd, rsp);
            `CHECK(rd, {24'h0, exp_mem})
            axi_read(`SSA_OFS_FLAGS, rd, rsp);
            `CHECK(rd, {28'h0, exp_flg})
        end
        // last command reads back with its unused bits zero
        axi_read(`SSA_OFS_CTRL, rd, rsp);
        `CHECK(rd, cmd)
        // a command without its low strobe has no effect
        axi_write(`SSA_OFS_CTRL, 32'h0001_0A02, 4'h0, rsp);
        `CHECK(rsp, `SSA_RESP_OKAY)
        axi_read(`SSA_OFS_ACC, rd, rsp);
        `CHECK(rd, 32'h12)
        // unmapped place refuses both ways
        axi_write(8'h0C, 32'h55, 4'hF, rsp);
        `CHECK(rsp, `SSA_RESP_SLVERR)
        axi_read(8'h0C, rd, rsp);
        `CHECK(rsp, `SSA_RESP_SLVERR)
        `CHECK(rd, 32'h0)
        // a second reset in mid-run clears what the cases left behind
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`SSA_OFS_ACC, rd, rsp);
        `CHECK(rd, 32'h0)
        axi_read(`SSA_OFS_FLAGS, rd, rsp);
        `CHECK(rd, 32'h0)
        axi_read(`SSA_OFS_MEM + 8'h28, rd, rsp);
        `CHECK(rd, 32'h0)
        final_report();
    end
endmodule // test_subtract_swap_alu_ops
